/* hdl/rxddr_out.v */
// Receive DDR parallel output: clock selection and A/B bus formatting.
// Assumes reference and recovered clocks are slow enough for clk_sys_in
// to sample; code words arrive from deserializer logic on clk_sys_in.
// Mode, compensation and coding pins are quasi-static and pass
// two flops; code words need none.
//
// Behaviour
// - Nibble and multiplexed modes drive main clock from buffered reference.
// - Compensation off gives main clock at one tenth recovered; nibble only.
// - Independent mode: each channel clock is its recovered clock.
// - Nibble mode channel clocks: one tenth recovered, or reference if enabled.
// - Multiplexed mode: G inverts main; pairs copy main and complement.
// - Multiplexed mode: channel B on rising edge, A on falling.
// - Nibble mode: low nibble on falling, high on rising; A low, B high.
// - Nibble mode decoded: bit 3 carries A's K flag in rising phase.
// - Multiplexed raw: bit 8 carries ninth bit of code word.
// - Multiplexed decoded: bit 8 high when byte is a K character.
// - Nibble raw: bit 8 carries B's fourth and ninth bits.
// - Nibble decoded: bit 8 is B's fourth bit, then B's K flag.
`timescale 1ns/10ps
`default_nettype none
`include "rxddr_defines.vh"

module rxddr_out #(
  parameter NUM_CHAN = `RXDDR_NUM_CHAN
) (
  input  wire                clk_sys_in,
  input  wire                rst_b_in,
  input  wire                reference_clock_in,
  input  wire [NUM_CHAN-1:0] rx_recovered_clk_in,
  input  wire [1:0]          mode_sel_in,
  input  wire                clock_tolerance_comp_in,
  input  wire                coding_enable_in,
  input  wire [9:0]          rx_code_a_in,
  input  wire [9:0]          rx_code_b_in,
  output reg                 rx_clock_chan_h_out,
  output reg  [NUM_CHAN-2:0] rx_clock_per_chan_out,
  output reg  [9:0]          rx_bus_pair_ab_out
);

  // ==========================================================
  // Reset release
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Configuration pin synchronisers
  // Quasi-static pins: a change reaches the selectors two cycles
  // late and may cut one clock phase short.
  reg [1:0] mode_meta_q;
  reg [1:0] mode_q;
  reg       comp_meta_q;
  reg       comp_q;
  reg       code_meta_q;
  reg       code_q;

  always @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_meta_q <= `RXDDR_MODE_RST;
      mode_q      <= `RXDDR_MODE_RST;
      comp_meta_q <= `RXDDR_COMP_RST;
      comp_q      <= `RXDDR_COMP_RST;
      code_meta_q <= `RXDDR_CODE_RST;
      code_q      <= `RXDDR_CODE_RST;
    end else begin
      mode_meta_q <= mode_sel_in;
      mode_q      <= mode_meta_q;
      comp_meta_q <= clock_tolerance_comp_in;
      comp_q      <= comp_meta_q;
      code_meta_q <= coding_enable_in;
      code_q      <= code_meta_q;
    end
  end

  // Decoded mode flags shared by the clock and bus selectors
  wire mode_nib;
  wire mode_mux;
  wire mode_ind;

  assign mode_nib = (mode_q == `RXDDR_MODE_NIBBLE);
  assign mode_mux = (mode_q == `RXDDR_MODE_MUX);
  assign mode_ind = (mode_q == `RXDDR_MODE_INDEP);

  // ==========================================================
  // Clock input synchronisers
  reg                ref_meta_q;
  reg                ref_q;
  reg [NUM_CHAN-1:0] rec_meta_q;
  reg [NUM_CHAN-1:0] rec_q;
  reg [NUM_CHAN-1:0] rec_prev_q;

  always @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      ref_meta_q <= `RXDDR_CLK_RST;
      ref_q      <= `RXDDR_CLK_RST;
      rec_meta_q <= {NUM_CHAN{1'b0}};
      rec_q      <= {NUM_CHAN{1'b0}};
      rec_prev_q <= {NUM_CHAN{1'b0}};
    end else begin
      ref_meta_q <= reference_clock_in;
      ref_q      <= ref_meta_q;
      rec_meta_q <= rx_recovered_clk_in;
      rec_q      <= rec_meta_q;
      rec_prev_q <= rec_q;
    end
  end

  // ==========================================================
  // Divide each recovered clock by ten
  wire [NUM_CHAN-1:0] rec_rise;
  wire [NUM_CHAN-1:0] div_clk;
  wire [NUM_CHAN-1:0] chan_clk;

  // Edges come from the second flop and its delayed copy only,
  // never from the first, which may still be settling.
  assign rec_rise = rec_q & ~rec_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_div
      reg [2:0] cnt_q;
      reg       div_q;
      always @(posedge clk_sys_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
          cnt_q <= 3'h0;
          div_q <= `RXDDR_CLK_RST;
        end else if (rec_rise[gi]) begin
          // Toggle every five recovered rises: ratio ten
          if (cnt_q == `RXDDR_DIV_HALF - 3'h1) begin
            cnt_q <= 3'h0;
            div_q <= ~div_q;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
      end
      assign div_clk[gi] = div_q;
      // Source for one channel clock before multiplexed pairing
      assign chan_clk[gi] =
        mode_ind ? rec_q[gi] :
        (comp_q ? ref_q : div_q);
    end
  endgenerate

  // ==========================================================
  // Main receive clock
  // Compensation off outside nibble mode is not a legal setting;
  // the reference clock is kept then in multiplexed mode, channel H's recovered clock in independent mode, so the bus keeps a clock.
  reg  main_d;
  wire comp_bypass;

  assign comp_bypass = !comp_q && mode_nib;

  always @* begin
    if (mode_ind)
      main_d = rec_q[NUM_CHAN-1];
    else if (comp_bypass)
      main_d = div_clk[0];
    else
      main_d = ref_q;
  end

  // ==========================================================
  // Clock outputs
  integer ci;
  reg [NUM_CHAN-2:0] per_d;

  always @* begin
    per_d = chan_clk[NUM_CHAN-2:0];
    if (mode_mux) begin
      // Odd letters (B, D, F) copy main, even (A, C, E, G) invert it
      for (ci = 0; ci < NUM_CHAN - 1; ci = ci + 1)
        per_d[ci] = (ci % 2 == 1) ? main_d : ~main_d;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rx_clock_chan_h_out   <= `RXDDR_CLK_RST;
      rx_clock_per_chan_out <= {(NUM_CHAN-1){1'b0}};
    end else begin
      rx_clock_chan_h_out   <= main_d;
      rx_clock_per_chan_out <= per_d;
    end
  end

  // ==========================================================
  // Decoders
  wire [7:0] dec_a;
  wire [7:0] dec_b;
  wire       k_a;
  wire       k_b;

  rxddr_dec8b10b u_dec_a (
    .code_in  (rx_code_a_in),
    .data_out (dec_a),
    .k_out    (k_a)
  );

  rxddr_dec8b10b u_dec_b (
    .code_in  (rx_code_b_in),
    .data_out (dec_b),
    .k_out    (k_b)
  );

  // ==========================================================
  // Bus phase tracking
  // Bus launches change with the clock driven out one cycle earlier,
  // so data edges trail the clock pin edges by one system cycle.
  wire bus_clk;
  reg  bus_clk_prev_q;
  wire bus_rise;
  wire bus_fall;

  // Independent mode times the shared A/B bus from channel A's clock
  assign bus_clk  = mode_ind ?
                    rx_clock_per_chan_out[0] : rx_clock_chan_h_out;
  assign bus_rise = bus_clk && !bus_clk_prev_q;
  assign bus_fall = !bus_clk && bus_clk_prev_q;

  // Held words: captured at the falling launch, used through the rise
  reg [9:0] hold_a_q;
  reg [9:0] hold_b_q;
  reg [7:0] hold_da_q;
  reg [7:0] hold_db_q;
  reg       hold_ka_q;
  reg       hold_kb_q;

  always @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bus_clk_prev_q <= `RXDDR_CLK_RST;
      hold_a_q       <= 10'h000;
      hold_b_q       <= 10'h000;
      hold_da_q      <= 8'h00;
      hold_db_q      <= 8'h00;
      hold_ka_q      <= 1'b0;
      hold_kb_q      <= 1'b0;
    end else begin
      bus_clk_prev_q <= bus_clk;
      if (bus_fall) begin
        hold_a_q  <= rx_code_a_in;
        hold_b_q  <= rx_code_b_in;
        hold_da_q <= dec_a;
        hold_db_q <= dec_b;
        hold_ka_q <= k_a;
        hold_kb_q <= k_b;
      end
    end
  end

  // ==========================================================
  // Bus formatting
  reg [9:0] fall_d;
  reg [9:0] rise_d;

  always @* begin
    fall_d = `RXDDR_BUS_RST;
    rise_d = `RXDDR_BUS_RST;
    if (mode_nib) begin
      if (code_q) begin
        // Low nibbles; B's fourth bit lands on bit 8
        fall_d = {1'b0, dec_b[3:0], 1'b0, dec_a[3:0]};
        // High nibbles around the K flags on bits 3 and 8
        rise_d = {hold_db_q[7], hold_kb_q, hold_db_q[6:4],
                  hold_da_q[7], hold_ka_q, hold_da_q[6:4]};
      end else begin
        fall_d = {rx_code_b_in[4:0], rx_code_a_in[4:0]};
        rise_d = {hold_b_q[9:5], hold_a_q[9:5]};
      end
    end else if (code_q) begin
      // Channel A first, then B; flag high marks a K character
      fall_d = {1'b0, k_a, dec_a};
      rise_d = {1'b0, hold_kb_q, hold_db_q};
    end else begin
      fall_d = rx_code_a_in;
      rise_d = hold_b_q;
    end
  end

  always @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q)
      rx_bus_pair_ab_out <= `RXDDR_BUS_RST;
    else if (bus_fall)
      rx_bus_pair_ab_out <= fall_d;
    else if (bus_rise)
      rx_bus_pair_ab_out <= rise_d;
  end

endmodule
`default_nettype wire

/* hdl/rxddr_defines.vh */
// Constants for the receive DDR parallel output block.
// Included by the design files; holds definitions only.
`ifndef RXDDR_DEFINES_VH
`define RXDDR_DEFINES_VH

// Interface mode select codes
`define RXDDR_MODE_NIBBLE  2'h0
`define RXDDR_MODE_MUX     2'h1
`define RXDDR_MODE_INDEP   2'h2

// Recovered clock divide ratio and its half period in recovered edges
`define RXDDR_DIV_RATIO    10
`define RXDDR_DIV_HALF     3'h5

// Channel count of the per-channel clocks, A through H
`define RXDDR_NUM_CHAN     8

// Reset values
`define RXDDR_BUS_RST      10'h000
`define RXDDR_CLK_RST      1'h0
`define RXDDR_MODE_RST     2'h0
`define RXDDR_COMP_RST     1'h1
`define RXDDR_CODE_RST     1'h0

// 8b/10b special patterns (abcdei and fghj order, a and f first)
`define RXDDR_K28_NEG      6'h0F
`define RXDDR_K28_POS      6'h30
`define RXDDR_ALT7_NEG     4'h7
`define RXDDR_ALT7_POS     4'h8

`endif

/* hdl/rxddr_dec8b10b.v */
// 8b/10b code group decoder, combinational.
// Assumes code bit 0 is bit a, the first bit received on the line.
`timescale 1ns/10ps
`default_nettype none
`include "rxddr_defines.vh"

module rxddr_dec8b10b (
  input  wire [9:0] code_in,
  output reg  [7:0] data_out,
  output reg        k_out
);

  // ==========================================================
  // Table lookups
  wire [5:0] six;
  wire [3:0] four;
  wire [3:0] four_rd;
  reg  [4:0] low5;
  reg  [2:0] high3;
  wire       k28;
  wire       alt7;

  assign six  = {code_in[0], code_in[1], code_in[2],
                 code_in[3], code_in[4], code_in[5]};
  assign four = {code_in[6], code_in[7], code_in[8], code_in[9]};
  // K28 after a positive six sends its trailing group inverted
  assign four_rd = (six == `RXDDR_K28_POS) ? ~four : four;
  assign k28  = (six == `RXDDR_K28_NEG) || (six == `RXDDR_K28_POS);
  assign alt7 = (four == `RXDDR_ALT7_NEG) || (four == `RXDDR_ALT7_POS);

  always @* begin
    case (six)
      6'h27, 6'h18: low5 = 5'h00;
      6'h1D, 6'h22: low5 = 5'h01;
      6'h2D, 6'h12: low5 = 5'h02;
      6'h31:        low5 = 5'h03;
      6'h35, 6'h0A: low5 = 5'h04;
      6'h29:        low5 = 5'h05;
      6'h19:        low5 = 5'h06;
      6'h38, 6'h07: low5 = 5'h07;
      6'h39, 6'h06: low5 = 5'h08;
      6'h25:        low5 = 5'h09;
      6'h15:        low5 = 5'h0A;
      6'h34:        low5 = 5'h0B;
      6'h0D:        low5 = 5'h0C;
      6'h2C:        low5 = 5'h0D;
      6'h1C:        low5 = 5'h0E;
      6'h17, 6'h28: low5 = 5'h0F;
      6'h1B, 6'h24: low5 = 5'h10;
      6'h23:        low5 = 5'h11;
      6'h13:        low5 = 5'h12;
      6'h32:        low5 = 5'h13;
      6'h0B:        low5 = 5'h14;
      6'h2A:        low5 = 5'h15;
      6'h1A:        low5 = 5'h16;
      6'h3A, 6'h05: low5 = 5'h17;
      6'h33, 6'h0C: low5 = 5'h18;
      6'h26:        low5 = 5'h19;
      6'h16:        low5 = 5'h1A;
      6'h36, 6'h09: low5 = 5'h1B;
      6'h0E, 6'h0F,
      6'h30:        low5 = 5'h1C;
      6'h2E, 6'h11: low5 = 5'h1D;
      6'h1E, 6'h21: low5 = 5'h1E;
      6'h2B, 6'h14: low5 = 5'h1F;
      default:      low5 = 5'h00;
    endcase
  end

  always @* begin
    case (four_rd)
      4'hB, 4'h4: high3 = 3'h0;
      4'h9:       high3 = 3'h1;
      4'h5:       high3 = 3'h2;
      4'hC, 4'h3: high3 = 3'h3;
      4'hD, 4'h2: high3 = 3'h4;
      4'hA:       high3 = 3'h5;
      4'h6:       high3 = 3'h6;
      default:    high3 = 3'h7;
    endcase
  end

  // Besides any K28 six, only x.7 alternate groups after these eight sixes are control codes
  always @* begin
    data_out = {high3, low5};
    k_out    = k28 || (alt7 && ((six == 6'h3A) || (six == 6'h05) ||
               (six == 6'h36) || (six == 6'h09) || (six == 6'h2E) ||
               (six == 6'h11) || (six == 6'h1E) || (six == 6'h21)));
  end

endmodule
`default_nettype wire

/* tb/rxddr_out_sva.sv */
// Checker for rxddr_out: clock selection and A/B bus words.
// Assumes the bench holds mode and code inputs for long stretches.
`timescale 1ns/10ps
`default_nettype none
module rxddr_out_sva #(
  parameter NUM_CHAN = 8
) (
  input wire logic                clk_sys_in,
  input wire logic                rst_b_in,
  input wire logic                reference_clock_in,
  input wire logic [NUM_CHAN-1:0] rx_recovered_clk_in,
  input wire logic [1:0]          mode_sel_in,
  input wire logic                clock_tolerance_comp_in,
  input wire logic                coding_enable_in,
  input wire logic [9:0]          rx_code_a_in,
  input wire logic [9:0]          rx_code_b_in,
  input wire logic                rx_clock_chan_h_out,
  input wire logic [NUM_CHAN-2:0] rx_clock_per_chan_out,
  input wire logic [9:0]          rx_bus_pair_ab_out
);
  // ======
  // Steadiness tracking
  logic [23:0] cfg_q;
  logic [6:0]  steady_q;
  logic [5:0]  run_q;
  logic        h1_q;
  logic        h2_q;
  logic [5:0]  run_g_q;
  logic        g1_q;
  wire         h = rx_clock_chan_h_out;
  wire         g = rx_clock_per_chan_out[NUM_CHAN-2];
  wire  [9:0]  bus = rx_bus_pair_ab_out;
  wire  [9:0]  a = rx_code_a_in;
  wire  [9:0]  b = rx_code_b_in;
  wire  [23:0] cfg = {mode_sel_in, clock_tolerance_comp_in,
                      coding_enable_in, a, b};
  // Mode switches may glitch, so only long-settled stretches count
  wire         live = steady_q == 7'h7F && cfg == cfg_q;
  wire         fell = h2_q && !h1_q;
  wire         rose = !h2_q && h1_q;
  wire         nib = mode_sel_in == 2'h0;
  wire         mux = mode_sel_in == 2'h1;
  wire         off = !clock_tolerance_comp_in;
  wire         cod = coding_enable_in;
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q <= 24'h0;
      steady_q <= 7'h0;
      run_q <= 6'h0;
      h1_q <= 1'b0;
      h2_q <= 1'b0;
      run_g_q <= 6'h0;
      g1_q <= 1'b0;
    end else begin
      cfg_q <= cfg;
      steady_q <= (cfg != cfg_q) ? 7'h0 : steady_q + {6'h0, ~&steady_q};
      run_q <= (h != h1_q) ? 6'h1 : run_q + {5'h0, ~&run_q};
      h1_q <= h;
      h2_q <= h1_q;
      run_g_q <= (g != g1_q) ? 6'h1 : run_g_q + {5'h0, ~&run_g_q};
      g1_q <= g;
    end
  end
  // ======
  // Properties
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  ref_mux_a: assert property (
    live && mux |-> h == $past(reference_clock_in, 3))
    else $error("main clock not the reference");
  ref_nib_a: assert property (
    live && nib && !off |-> h == $past(reference_clock_in, 3) &&
    rx_clock_per_chan_out == {(NUM_CHAN-1){h}})
    else $error("nibble clocks not the reference");
  pair_clk_a: assert property (
    live && mux |-> rx_clock_per_chan_out == (h ? 7'h2A : 7'h55))
    else $error("paired clocks wrong");
  own_clk_a: assert property (
    live && mode_sel_in == 2'h2 |->
    {h, rx_clock_per_chan_out} == $past(rx_recovered_clk_in, 3))
    else $error("channel clock not its recovered clock");
  div_half_a: assert property (
    live && nib && off && $changed(h) |-> run_q == 6'h28)
    else $error("divided clock half period wrong");
  div_chan_a: assert property (
    live && nib && off |-> rx_clock_per_chan_out[0] == h)
    else $error("channel A divided clock off main");
  div_chan_g_a: assert property (
    live && nib && off && $changed(g) |-> run_g_q == 6'h28)
    else $error("channel G divided clock half period wrong");
  nib_fall_a: assert property (
    live && nib && !cod && fell |-> bus == {b[4:0], a[4:0]})
    else $error("nibble low word wrong");
  nib_rise_a: assert property (
    live && nib && !cod && rose |-> bus == {b[9:5], a[9:5]})
    else $error("nibble high word wrong");
  mux_fall_a: assert property (
    live && mux && !cod && fell |-> bus == a)
    else $error("channel A word wrong");
  mux_rise_a: assert property (
    live && mux && !cod && rose |-> bus == b)
    else $error("channel B word wrong");
endmodule
bind rxddr_out rxddr_out_sva #(.NUM_CHAN(NUM_CHAN)) chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .reference_clock_in(reference_clock_in),
  .rx_recovered_clk_in(rx_recovered_clk_in), .mode_sel_in(mode_sel_in),
  .clock_tolerance_comp_in(clock_tolerance_comp_in),
  .coding_enable_in(coding_enable_in), .rx_code_a_in(rx_code_a_in),
  .rx_code_b_in(rx_code_b_in), .rx_clock_chan_h_out(rx_clock_chan_h_out),
  .rx_clock_per_chan_out(rx_clock_per_chan_out),
  .rx_bus_pair_ab_out(rx_bus_pair_ab_out));
`default_nettype wire

/* tb/rxddr_host_model.sv */
// Protocol-side model: latches the A/B bus on both bus clock edges.
// Assumes the bus settles one system cycle after each clock edge.
`timescale 1ns/10ps
`default_nettype none
module rxddr_host_model (
  input  wire logic        clk_in,
  input  wire logic        bclk_in,
  input  wire logic [9:0]  bus_in,
  output var  logic [9:0]  fall_word_out,
  output var  logic [9:0]  rise_word_out,
  output var  logic [15:0] rise_cnt_out
);
  logic b1_q = 1'b0;
  logic b2_q = 1'b0;
  initial rise_cnt_out = 16'h0;
  // Latch a cycle late: the bus register trails its clock output
  always @(posedge clk_in) begin
    b1_q <= bclk_in;
    b2_q <= b1_q;
    if (b2_q && !b1_q) fall_word_out <= bus_in;
    if (!b2_q && b1_q) begin
      rise_word_out <= bus_in;
      rise_cnt_out <= rise_cnt_out + 16'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/test_rxddr_out.sv */
// Testbench for rxddr_out: every mode, raw and decoded words.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/10ps
`default_nettype none
module test_rxddr_out;
  logic        clk_sys_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ref_clk = 1'b0;
  logic [7:0]  rec_clk = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        comp = 1'b1;
  logic        coding = 1'b0;
  logic [9:0]  code_a = 10'h000;
  logic [9:0]  code_b = 10'h000;
  wire         h;
  wire  [6:0]  pc;
  wire  [9:0]  bus;
  wire  [9:0]  fall_w;
  wire  [9:0]  rise_w;
  wire  [15:0] rise_n;
  int          bad_count = 0;
  int          check_count = 0;

  rxddr_out dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .reference_clock_in(ref_clk), .rx_recovered_clk_in(rec_clk),
    .mode_sel_in(mode), .clock_tolerance_comp_in(comp),
    .coding_enable_in(coding), .rx_code_a_in(code_a),
    .rx_code_b_in(code_b), .rx_clock_chan_h_out(h),
    .rx_clock_per_chan_out(pc), .rx_bus_pair_ab_out(bus));
  rxddr_host_model host (.clk_in(clk_sys_in),
    .bclk_in(mode == 2'h2 ? pc[0] : h), .bus_in(bus),
    .fall_word_out(fall_w), .rise_word_out(rise_w),
    .rise_cnt_out(rise_n));

  // ======
  // Clocks: link clocks 400 ns, phases apart from the system clock
  initial forever #25 clk_sys_in = ~clk_sys_in;
  initial begin
    #13;
    forever #200 ref_clk = ~ref_clk;
  end
  for (genvar i = 0; i < 8; i++) begin : g_rec
    initial begin
      #(3 + 52 * i);
      forever #200 rec_clk[i] = ~rec_clk[i];
    end
  end

  // ======
  // Tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Decoded values ({k, byte}) are given, never derived here
  task automatic run(input logic [1:0] m, input logic cp, input logic cd,
                     input logic [9:0] a, input logic [9:0] b,
                     input logic [8:0] da, input logic [8:0] db);
    logic [9:0]  ef;
    logic [9:0]  er;
    logic [15:0] n0;
    int          i;
    @(posedge clk_sys_in);
    mode <= m;
    comp <= cp;
    coding <= cd;
    code_a <= a;
    code_b <= b;
    case ({m == 2'h0, cd})
      2'b10: begin
        ef = {b[4:0], a[4:0]};
        er = {b[9:5], a[9:5]};
      end
      2'b11: begin
        ef = {1'b0, db[3:0], 1'b0, da[3:0]};
        er = {db[7], db[8], db[6:4], da[7], da[8], da[6:4]};
      end
      2'b00: begin
        ef = a;
        er = b;
      end
      default: begin
        ef = {1'b0, da};
        er = {1'b0, db};
      end
    endcase
    @(posedge clk_sys_in);
    n0 = rise_n;
    for (i = 0; i < 2000 && rise_n < n0 + 16'h14; i++) @(posedge clk_sys_in);
    // A stalled bus clock counts once; the verdict still comes last
    if (i == 2000) begin
      bad_count++;
    end else begin
      chk(fall_w, ef);
      chk(rise_w, er);
    end
  endtask

  // ======
  // Sequence
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    run(2'h0, 1'b1, 1'b0, 10'h2B7, 10'h1C9, 9'h0, 9'h0);
    run(2'h0, 1'b0, 1'b0, 10'h1C9, 10'h2B7, 9'h0, 9'h0);
    run(2'h0, 1'b1, 1'b1, 10'h17C, 10'h155, 9'h1BC, 9'h0B5);
    run(2'h0, 1'b0, 1'b1, 10'h2AA, 10'h17C, 9'h04A, 9'h1BC);
    run(2'h1, 1'b1, 1'b0, 10'h1C9, 10'h2B7, 9'h0, 9'h0);
    run(2'h1, 1'b1, 1'b1, 10'h17C, 10'h155, 9'h1BC, 9'h0B5);
    run(2'h1, 1'b1, 1'b1, 10'h2AA, 10'h17C, 9'h04A, 9'h1BC);
    run(2'h2, 1'b1, 1'b0, 10'h2B7, 10'h1C9, 9'h0, 9'h0);
    run(2'h2, 1'b1, 1'b1, 10'h155, 10'h17C, 9'h0B5, 9'h1BC);
    final_report();
  end
endmodule
`default_nettype wire
